// ### hdl/bbx_pkg.sv
package bbx_pkg;
  // Opcode field values, bit 0 is the MSB of the instruction word
  localparam logic [5:0] OPC_BNE_REG = 6'h27; // 100111
  localparam logic [5:0] OPC_BNE_IMM = 6'h2f; // 101111
  localparam logic [5:0] OPC_JMP_REG = 6'h26; // 100110
  localparam logic [5:0] OPC_JMP_IMM = 6'h2e; // 101110
  localparam logic [5:0] OPC_BSHIFT  = 6'h11; // 010001
  // Condition code for not-equal in the rD slot, D in its top bit
  localparam logic [3:0] COND_NE     = 4'h1;
  // Break is the unconditional opcode with D,A,L field = 0,1,1 and low 2 zero
  localparam logic [4:0] BRK_SEL     = 5'h0c;
  // Field positions in little-endian numbering (ls bit = index 0)
  localparam int         RD_LSB      = 21;
  localparam int         RA_LSB      = 16;
  localparam int         RB_LSB      = 11;
  localparam int         OPC_LSB     = 26;
  localparam int         DLY_BIT_C   = 25; // conditional D (instr bit 6)
  localparam int         DLY_BIT_U   = 20; // unconditional D (instr bit 11)
  localparam int         ABS_BIT     = 19; // A (instr bit 12)
  localparam int         LNK_BIT     = 18; // L (instr bit 13)
  localparam int         SIDE_BIT    = 10; // S (instr bit 21)
  localparam int         TYPE_BIT    = 9;  // T (instr bit 22)
  localparam int         BIP_BIT     = 3;  // break flag position in status
  localparam logic [31:0] PC_STEP    = 32'h0000_0004;
  localparam logic [31:0] PC_RESET   = 32'h0000_0000;
  // Busy cycles beyond the first for each latency class
  localparam logic [1:0] EXTRA_TAKEN_DLY  = 2'h1; // 2 cycles total
  localparam logic [1:0] EXTRA_TAKEN_NDLY = 2'h2; // 3 cycles total
  localparam logic [1:0] EXTRA_SHIFT      = 2'h1; // 2 cycles total
  localparam logic [1:0] EXTRA_NONE       = 2'h0; // 1 cycle total

  typedef enum logic [2:0] {
    BBX_IDLE = 3'h1,
    BBX_WAIT = 3'h2,
    BBX_DONE = 3'h4
  } bbx_state_t;
endpackage

// ### hdl/bbx_shift_if.sv
`timescale 1ns/10ps
interface bbx_shift_if;
  logic        start;
  logic [31:0] operand;
  logic [4:0]  amount;
  logic        go_left;
  logic        arith;
  logic [31:0] result;
  logic        valid;
  modport ctrl (output start, operand, amount, go_left, arith,
                input result, valid);
  modport unit (input start, operand, amount, go_left, arith,
                output result, valid);
endinterface

// ### hdl/bbx_barrel_shifter.sv
`timescale 1ns/10ps
module bbx_barrel_shifter
  import bbx_pkg::*;
(
  input  wire logic  i_core_clk,
  input  wire logic  i_rst_n,
  bbx_shift_if.unit  sh
);
  logic [31:0] res_d, res_q;
  logic        vld_d, vld_q;

  // One registered stage; arithmetic repeats the operand's sign bit
  always_comb begin
    vld_d = sh.start;
    if (sh.go_left) begin
      res_d = sh.operand << sh.amount;
    end else if (sh.arith) begin
      res_d = $unsigned($signed(sh.operand) >>> sh.amount);
    end else begin
      res_d = sh.operand >> sh.amount;
    end
  end

  always_ff @(posedge i_core_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      res_q <= 32'h0;
      vld_q <= 1'b0;
    end else begin
      res_q <= res_d;
      vld_q <= vld_d;
    end
  end

  assign sh.result = res_q;
  assign sh.valid  = vld_q;
endmodule // bbx_barrel_shifter

// ### hdl/bbx_branch_shift_exec.sv
`timescale 1ns/10ps
// Functional notes
// RULE1 - Register not-equal: nonzero source gives pc+offset, else pc+4
// RULE2 - Immediate not-equal adds sign-extended 16-bit immediate when taken
// RULE3 - Delay flag lets one slot instruction run before the target
// RULE4 - Conditional: 1 cycle untaken, 2 taken with delay, 3 without
// RULE5 - Conditional branches update only the program counter
// RULE6 - Linking jumps write current pc to destination before redirect
// RULE7 - Register jump: absolute uses offset, else pc plus offset
// RULE8 - Immediate jump uses sign-extended immediate, absolute or relative
// RULE9 - Unconditional jump: 2 cycles with delay, 3 without
// RULE10 - Register jump link without delay is not offered
// RULE11 - Immediate jump link without delay is not offered
// RULE12 - Register break links pc and jumps to offset absolutely
// RULE13 - Both breaks set the break-in-progress status flag
// RULE14 - Immediate break links, jumps to sign-extended immediate, 3 cycles
// RULE15 - Barrel shift by low five bits of shift-amount register
// RULE16 - Side flag set shifts left, clear shifts right
// RULE17 - Type flag set gives arithmetic right shift keeping sign bit
// RULE18 - Barrel shift takes 2 cycles and is optional
// RULE19 - Immediates sign-extend unless a prefix supplies upper half
// RULE20 - Instruction bit 0 is the most significant bit
// RULE21 - Unsupported encodings are undefined and treated as no-ops
module bbx_branch_shift_exec
  import bbx_pkg::*;
#(
  parameter bit HAS_SHIFTER = 1'b1
) (
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_instr_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [31:0] i_pc,
  input  wire logic [31:0] i_source_one_gpr,
  input  wire logic [31:0] i_offset_gpr,
  input  wire logic        i_imm_prefix_valid,
  input  wire logic [15:0] i_imm_prefix,
  output logic             o_busy,
  output logic             o_done,
  output logic             o_pc_we,
  output logic [31:0]      o_pc_next,
  output logic             o_delay_slot,
  output logic             o_flush,
  output logic             o_gpr_we,
  output logic [4:0]       o_gpr_addr,
  output logic [31:0]      o_gpr_wdata,
  output logic             o_bip_set,
  output logic             o_illegal
);
  // Reset release through two flops
  logic rst_s1_q, rst_n;
  always_ff @(posedge i_core_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      rst_s1_q <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_s1_q <= 1'b1;
      rst_n    <= rst_s1_q;
    end
  end

  // RULE19 sign extension
  function automatic logic [31:0] sext16(input logic [15:0] v);
    sext16 = {{16{v[15]}}, v};
  endfunction

  // RULE20 MSB-first field select
  function automatic logic [4:0] fld5(input logic [31:0] w, input int lsb);
    fld5 = w[lsb +: 5];
  endfunction

  // Decode of the presented instruction
  logic [5:0]  opc;
  logic [31:0] imm32;
  logic        is_bne, is_bnei, is_jr, is_ji, is_brk, is_brki, is_bs;
  logic        dly_c, dly_u, abs_f, lnk_f, undef_link;
  logic [4:0]  ctl5;

  always_comb begin
    opc   = i_instr[OPC_LSB +: 6];
    ctl5  = fld5(i_instr, RB_LSB + 5);
    dly_c = i_instr[DLY_BIT_C];
    dly_u = i_instr[DLY_BIT_U];
    abs_f = i_instr[ABS_BIT];
    lnk_f = i_instr[LNK_BIT];
    // RULE19 prefix overrides the upper half
    imm32 = i_imm_prefix_valid ? {i_imm_prefix, i_instr[15:0]}
                               : sext16(i_instr[15:0]);
    is_bne  = (opc == OPC_BNE_REG) &&
              (i_instr[24:21] == COND_NE);
    is_bnei = (opc == OPC_BNE_IMM) &&
              (i_instr[24:21] == COND_NE);
    is_brk  = (opc == OPC_JMP_REG) && (ctl5 == BRK_SEL);
    is_brki = (opc == OPC_JMP_IMM) && (ctl5 == BRK_SEL);
    // RULE10 RULE11 link needs delay
    undef_link = lnk_f && !dly_u && !is_brk && !is_brki;
    is_jr   = (opc == OPC_JMP_REG) && !is_brk;
    is_ji   = (opc == OPC_JMP_IMM) && !is_brki;
    is_bs   = HAS_SHIFTER && (opc == OPC_BSHIFT);
  end

  // Shifter instance, always built; HAS_SHIFTER only gates the shift decode
  bbx_shift_if sh ();
  bbx_barrel_shifter u_shift (
    .i_core_clk (i_core_clk),
    .i_rst_n    (rst_n),
    .sh         (sh)
  );

  // Relative targets add to the branch's own pc; absolute ones replace it
  function automatic logic [31:0] br_target(input logic [31:0] pc,
                                            input logic [31:0] base,
                                            input logic        absolute);
    br_target = absolute ? base : pc + base;
  endfunction

  // Sequencer state
  bbx_state_t  st_d, st_q;
  logic [1:0]  cnt_d, cnt_q;
  logic [4:0]  rd_d, rd_q;
  logic        wb_sh_d, wb_sh_q;
  logic        taken;
  logic [31:0] opnd;

  // Result pulses and their next values
  logic        pc_we_d, gpr_we_d, bip_d, flush_d, dslot_d, done_d, ill_d;
  logic        pc_we_q, gpr_we_q, bip_q, flush_q, dslot_q, done_q, ill_q;
  logic [31:0] pc_nx_d, pc_nx_q;
  logic [31:0] gpr_wd_d, gpr_wd_q;
  logic [4:0]  gpr_a_d, gpr_a_q;

  // Next state and issue decisions. All an instruction changes, save a
  // shift's register write, is settled on the edge that takes it, so the slot
  // or target fetch can start at once; later cycles count down, retire and write a shift result.
  always_comb begin
    st_d     = st_q;
    cnt_d    = cnt_q;
    rd_d     = rd_q;
    wb_sh_d  = 1'b0;
    pc_we_d  = 1'b0;
    gpr_we_d = 1'b0;
    bip_d    = 1'b0;
    flush_d  = 1'b0;
    dslot_d  = 1'b0;
    done_d   = 1'b0;
    ill_d    = 1'b0;
    // Untaken branches and shifts both step one word
    pc_nx_d  = i_pc + PC_STEP;
    // Link value is always the instruction's own pc
    gpr_wd_d = i_pc;
    gpr_a_d  = rd_q;
    taken    = 1'b0;
    // Register forms take the offset register, immediate forms the field
    opnd     = (is_bne || is_jr || is_brk) ? i_offset_gpr : imm32;
    // Shifter inputs follow the presented word; only start is gated
    sh.start   = 1'b0;
    sh.operand = i_source_one_gpr;
    // RULE15 low five bits of amount
    sh.amount  = i_offset_gpr[4:0];
    // RULE16 side flag
    sh.go_left = i_instr[SIDE_BIT];
    // RULE17 type flag
    sh.arith   = i_instr[TYPE_BIT];
    case (st_q)
      BBX_IDLE: begin
        // Destination index follows the presented word while idle
        gpr_a_d = fld5(i_instr, RD_LSB);
        if (i_instr_valid) begin
          rd_d = fld5(i_instr, RD_LSB);
          if (is_bne || is_bnei) begin
            // RULE1 RULE2 nonzero test
            taken   = (i_source_one_gpr != 32'h0);
            pc_we_d = 1'b1;
            if (taken) begin
              pc_nx_d = br_target(i_pc, opnd, 1'b0);
            end
            // RULE4 RULE3 latency and slot
            dslot_d = taken && dly_c;
            flush_d = taken && !dly_c;
            cnt_d   = !taken ? EXTRA_NONE :
                      (dly_c ? EXTRA_TAKEN_DLY : EXTRA_TAKEN_NDLY);
          end else if (is_brk || is_brki) begin
            // RULE12 RULE14 absolute target, link
            pc_we_d  = 1'b1;
            pc_nx_d  = br_target(i_pc, opnd, 1'b1);
            gpr_we_d = 1'b1;
            // RULE13 break flag
            bip_d    = 1'b1;
            // Breaks have no slot, so the next word is dropped
            flush_d  = 1'b1;
            cnt_d    = EXTRA_TAKEN_NDLY;
          end else if ((is_jr || is_ji) && !undef_link) begin
            // RULE7 RULE8 target select
            pc_we_d  = 1'b1;
            pc_nx_d  = br_target(i_pc, opnd, abs_f);
            // RULE6 link write
            gpr_we_d = lnk_f;
            // RULE9 RULE3 latency and slot
            dslot_d  = dly_u;
            flush_d  = !dly_u;
            cnt_d    = dly_u ? EXTRA_TAKEN_DLY : EXTRA_TAKEN_NDLY;
          end else if (is_bs) begin
            // RULE18 two-cycle shift
            sh.start = 1'b1;
            wb_sh_d  = 1'b1;
            pc_we_d  = 1'b1;
            cnt_d    = EXTRA_SHIFT;
          end else begin
            // RULE21 undefined: no state changes
            // Nothing is written, so a core may ignore the pulse safely
            ill_d = 1'b1;
            cnt_d = EXTRA_NONE;
          end
          // RULE5 conditional paths never raise gpr_we
          // Counter keeps the busy cycles left after the next one
          if (ill_d || cnt_d == EXTRA_NONE) begin
            done_d = 1'b1;
          end else begin
            st_d  = (cnt_d == 2'h1) ? BBX_DONE : BBX_WAIT;
            cnt_d = cnt_d - 2'h1;
          end
        end
      end
      BBX_WAIT: begin
        // Dead cycle while fetch refills after a flush
        st_d    = BBX_DONE;
        cnt_d   = 2'h0;
        wb_sh_d = wb_sh_q;
      end
      BBX_DONE: begin
        st_d   = BBX_IDLE;
        done_d = 1'b1;
        // Shift result already sits in the unit's output flop
        if (wb_sh_q && sh.valid) begin
          gpr_we_d = 1'b1;
          gpr_wd_d = sh.result;
        end
      end
      default: begin
        st_d = BBX_IDLE;
      end
    endcase
  end

  // Sequencer registers only; decisions live in the process above
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q    <= BBX_IDLE;
      cnt_q   <= 2'h0;
      rd_q    <= 5'h0;
      wb_sh_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      rd_q    <= rd_d;
      wb_sh_q <= wb_sh_d;
    end
  end

  // Result flops; each pulse lasts one cycle because every next value
  // defaults low in the decision process
  always_ff @(posedge i_core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pc_we_q  <= 1'b0;
      gpr_we_q <= 1'b0;
      bip_q    <= 1'b0;
      flush_q  <= 1'b0;
      dslot_q  <= 1'b0;
      done_q   <= 1'b0;
      ill_q    <= 1'b0;
      pc_nx_q  <= PC_RESET;
      gpr_wd_q <= 32'h0;
      gpr_a_q  <= 5'h0;
    end else begin
      pc_we_q  <= pc_we_d;
      gpr_we_q <= gpr_we_d;
      bip_q    <= bip_d;
      flush_q  <= flush_d;
      dslot_q  <= dslot_d;
      done_q   <= done_d;
      ill_q    <= ill_d;
      pc_nx_q  <= pc_nx_d;
      gpr_wd_q <= gpr_wd_d;
      gpr_a_q  <= gpr_a_d;
    end
  end

  // Busy decodes state so a refused word costs no extra cycle
  assign o_busy       = (st_q != BBX_IDLE);
  assign o_done       = done_q;
  assign o_pc_we      = pc_we_q;
  assign o_pc_next    = pc_nx_q;
  assign o_delay_slot = dslot_q;
  assign o_flush      = flush_q;
  assign o_gpr_we     = gpr_we_q;
  assign o_gpr_addr   = gpr_a_q;
  assign o_gpr_wdata  = gpr_wd_q;
  assign o_bip_set    = bip_q;
  assign o_illegal    = ill_q;
endmodule // bbx_branch_shift_exec

// ### verification/bbx_chk_sva.sv
`timescale 1ns/10ps
module bbx_chk_sva
  import bbx_pkg::*;
(
  input  wire logic        i_core_clk,
  input  wire logic        i_rstn,
  input  wire logic        i_instr_valid,
  input  wire logic [31:0] i_instr,
  input  wire logic [31:0] i_pc,
  input  wire logic [31:0] i_source_one_gpr,
  input  wire logic [31:0] i_offset_gpr,
  input  wire logic        o_busy,
  input  wire logic        o_done,
  input  wire logic        o_pc_we,
  input  wire logic [31:0] o_pc_next,
  input  wire logic        o_delay_slot,
  input  wire logic        o_flush,
  input  wire logic        o_gpr_we,
  input  wire logic [4:0]  o_gpr_addr,
  input  wire logic [31:0] o_gpr_wdata,
  input  wire logic        o_bip_set,
  input  wire logic        o_illegal
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rstn);
  logic       tk, cnd, jmp, brk, lnk, sh, nz;
  logic [5:0] opc;
  logic [4:0] rd;
  // Decode of what is taken; busy gates it like the core does
  assign opc = i_instr[31:26];
  assign rd  = i_instr[25:21];
  assign nz  = i_source_one_gpr != 32'h0;
  assign tk  = i_instr_valid && !o_busy;
  assign cnd = tk && (opc == OPC_BNE_REG || opc == OPC_BNE_IMM)
               && i_instr[24:21] == COND_NE;
  assign jmp = tk && (opc == OPC_JMP_REG || opc == OPC_JMP_IMM);
  assign brk = jmp && i_instr[20:16] == BRK_SEL;
  assign lnk = jmp && !brk && i_instr[LNK_BIT];
  assign sh  = tk && opc == OPC_BSHIFT;

  property p_untaken;
    cnd && !nz |=> o_pc_we && o_done && o_pc_next == $past(i_pc) + PC_STEP;
  endproperty
  a_untaken: assert property (p_untaken) else $error("untaken pc wrong");
  property p_tk_dly;
    cnd && nz && i_instr[DLY_BIT_C] |=> o_delay_slot && !o_flush ##1 o_done;
  endproperty
  a_tk_dly: assert property (p_tk_dly) else $error("delay branch wrong");
  property p_tk_nd;
    cnd && nz && !i_instr[DLY_BIT_C] |=> o_flush && !o_done ##1 !o_done
      ##1 o_done;
  endproperty
  a_tk_nd: assert property (p_tk_nd) else $error("flush branch wrong");
  property p_pc_only;
    cnd |=> (!o_gpr_we && !o_bip_set) ##1
      ((!o_gpr_we && !o_bip_set) || !$past(o_busy)) [*2];
  endproperty
  a_pc_only: assert property (p_pc_only) else $error("branch wrote gpr");
  property p_link;
    lnk && i_instr[DLY_BIT_U] |=> o_gpr_we && o_gpr_wdata == $past(i_pc)
      && o_gpr_addr == $past(rd);
  endproperty
  a_link: assert property (p_link) else $error("link write wrong");
  property p_abs;
    jmp && !brk && i_instr[ABS_BIT] && opc == OPC_JMP_REG
      |=> o_pc_next == $past(i_offset_gpr);
  endproperty
  a_abs: assert property (p_abs) else $error("absolute target wrong");
  property p_jlat;
    jmp && i_instr[DLY_BIT_U] |=> !o_done ##1 o_done;
  endproperty
  a_jlat: assert property (p_jlat) else $error("jump latency wrong");
  property p_illegal;
    lnk && !i_instr[DLY_BIT_U] |=> o_illegal && !o_pc_we && !o_gpr_we;
  endproperty
  a_illegal: assert property (p_illegal) else $error("link no delay ran");
  property p_brk;
    brk |=> o_bip_set && o_gpr_we && o_flush ##2 o_done;
  endproperty
  a_brk: assert property (p_brk) else $error("break wrong");
  property p_shift;
    sh |=> !o_gpr_we ##1 o_gpr_we && o_done && o_gpr_addr == $past(rd, 2);
  endproperty
  a_shift: assert property (p_shift) else $error("shift timing wrong");
  // Main scenarios reached
  c_brk: cover property (brk);
  c_sh:  cover property (sh);
  c_dly: cover property (o_delay_slot);
endmodule // bbx_chk_sva

// ### verification/bbx_branch_shift_exec_tb.sv
`timescale 1ns/10ps
module bbx_branch_shift_exec_tb;
  import bbx_pkg::*;
  logic        clk  = 1'b0;
  logic        rstn = 1'b0;
  logic        vld  = 1'b0;
  logic        pv   = 1'b0;
  logic [15:0] pw   = 16'h0;
  logic [31:0] ins  = 32'h0;
  logic [31:0] pc   = 32'h0;
  logic [31:0] ra   = 32'h0;
  logic [31:0] rb   = 32'h0;
  logic        busy, done, pwe, dly, fl, gwe, break_in_progress_flag, ill;
  logic [31:0] pcn, gwd;
  logic [4:0]  gad;
  logic [36:0] pq[$]; // Notes: illegal, pc write, bip, flush, slot, pc
  logic [36:0] gq[$]; // Notes: gpr address, data
  logic [15:0] lo;
  int          error_cnt = 0;
  int          checks_done = 0;

  always #10 clk = ~clk;

  bbx_branch_shift_exec #(.HAS_SHIFTER(1'b1)) bbx_branch_shift_exec_i (
    .i_core_clk(clk), .i_rstn(rstn), .i_instr_valid(vld), .i_instr(ins),
    .i_pc(pc), .i_source_one_gpr(ra), .i_offset_gpr(rb),
    .i_imm_prefix_valid(pv), .i_imm_prefix(pw), .o_busy(busy),
    .o_done(done), .o_pc_we(pwe), .o_pc_next(pcn), .o_delay_slot(dly),
    .o_flush(fl), .o_gpr_we(gwe), .o_gpr_addr(gad), .o_gpr_wdata(gwd),
    .o_bip_set(break_in_progress_flag), .o_illegal(ill));

  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic bad(input string m);
    error_cnt++;
    $display("BAD %0t %s", $time, m);
  endtask

  task automatic cmp_pc(input logic [36:0] g, input logic [36:0] e);
    checks_done++;
    if (g !== e) bad($sformatf("pc got %h exp %h", g, e));
  endtask

  task automatic cmp_gpr(input logic [36:0] g, input logic [36:0] e);
    checks_done++;
    if (g !== e) bad($sformatf("gpr got %h exp %h", g, e));
  endtask

  task automatic cmp_lat(input int g, input int e);
    checks_done++;
    if (g != e) bad($sformatf("latency got %0d exp %0d", g, e));
  endtask

  // Reference model notes results, then the op is held until retired
  task automatic op(input logic [31:0] i, p, a, b);
    logic [31:0] im, off, t, r;
    logic        tk, d;
    int          lat, n, nb;
    im  = pv ? {pw, i[15:0]} : {{16{i[15]}}, i[15:0]};
    off = i[29] ? im : b; // Immediate forms have opcode bit 29 set
    t   = p + PC_STEP;
    lat = 1;
    case (i[31:26])
      OPC_BNE_REG, OPC_BNE_IMM: begin
        tk  = a != 32'h0;
        d   = i[DLY_BIT_C];
        lat = tk ? (d ? 2 : 3) : 1;
        pq.push_back({3'b010, tk & !d, tk & d, tk ? p + off : t});
      end
      OPC_JMP_REG, OPC_JMP_IMM: begin
        d = i[DLY_BIT_U];
        if (i[20:16] == BRK_SEL) begin
          lat = 3;
          pq.push_back({5'h0e, off});
          gq.push_back({i[25:21], p});
        end else if (i[LNK_BIT] && !d) begin
          pq.push_back({1'b1, 36'h0});
        end else begin
          lat = d ? 2 : 3;
          pq.push_back({3'b010, !d, d, i[ABS_BIT] ? off : p + off});
          if (i[LNK_BIT]) gq.push_back({i[25:21], p});
        end
      end
      default: begin
        lat = 2;
        r = a >> b[4:0];
        if (i[TYPE_BIT]) r = $signed(a) >>> b[4:0];
        if (i[SIDE_BIT]) r = a << b[4:0];
        pq.push_back({5'h08, t});
        gq.push_back({i[25:21], r});
      end
    endcase
    ins = i;
    pc  = p;
    ra  = a;
    rb  = b;
    vld = 1'b1;
    n   = 0;
    nb  = 0;
    do begin
      @(negedge clk);
      n++;
      if (busy === 1'b1) nb++;
    end while (done !== 1'b1 && n < 8);
    if (n == 8) begin
      bad("no completion");
      results();
    end
    cmp_lat(n, lat);
    cmp_lat(nb, lat - 1);
  endtask

  task automatic end_test(input string s);
    vld = 1'b0;
    @(negedge clk);
    $display("test %s finished", s);
  endtask

  // Outputs are checked against the oldest note of their kind
  always @(negedge clk) begin
    if (pwe === 1'b1 || ill === 1'b1) begin
      if (pq.size() == 0) bad("unexpected pc update");
      else cmp_pc({ill, pwe, break_in_progress_flag, fl, dly, ill ? 32'h0 : pcn},
                  pq.pop_front());
    end
    if (gwe === 1'b1) begin
      if (gq.size() == 0) bad("unexpected gpr write");
      else cmp_gpr({gad, gwd}, gq.pop_front());
    end
  end

  initial begin
    void'($urandom(32'h7e5e375b));
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    repeat (3) @(negedge clk);
    for (int k = 0; k < 8; k++) begin
      lo = k[2] ? 16'($urandom()) : 16'h2000;
      op({k[2] ? OPC_BNE_IMM : OPC_BNE_REG, k[0], COND_NE, 5'h03, lo},
         $urandom() & 32'hffff_fffc, k[1] ? $urandom() | 32'h1 : 32'h0,
         $urandom());
    end
    pv = 1'b1;
    pw = 16'($urandom());
    op({OPC_BNE_IMM, 1'b1, COND_NE, 5'h03, 16'h8004}, 32'h100, 32'h1,
       32'h0);
    pv = 1'b0;
    end_test("not equal");
    for (int k = 0; k < 16; k++) begin
      lo = k[3] ? 16'($urandom()) : 16'h2800;
      op({k[3] ? OPC_JMP_IMM : OPC_JMP_REG, 5'($urandom()), k[2:0], 2'b00,
          lo}, $urandom() & 32'hffff_fffc, $urandom(),
         $urandom());
    end
    end_test("jump and break");
    for (int k = 0; k < 8; k++) begin
      op({OPC_BSHIFT, 5'($urandom()), 5'h01, 5'h02, k[0], k[1], 9'h0},
         $urandom() & 32'hffff_fffc, $urandom() | 32'h8000_0000,
         $urandom() | (k[2] ? 32'h1f : 32'h0));
    end
    end_test("barrel shift");
    if (pq.size() != 0 || gq.size() != 0) bad("results missing");
    results();
  end
endmodule // bbx_branch_shift_exec_tb

bind bbx_branch_shift_exec bbx_chk_sva bbx_chk_sva_i (
  .i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_instr_valid(i_instr_valid),
  .i_instr(i_instr), .i_pc(i_pc), .i_source_one_gpr(i_source_one_gpr),
  .i_offset_gpr(i_offset_gpr), .o_busy(o_busy), .o_done(o_done),
  .o_pc_we(o_pc_we), .o_pc_next(o_pc_next), .o_delay_slot(o_delay_slot),
  .o_flush(o_flush), .o_gpr_we(o_gpr_we), .o_gpr_addr(o_gpr_addr),
  .o_gpr_wdata(o_gpr_wdata), .o_bip_set(o_bip_set), .o_illegal(o_illegal));
